// [shared/mfm_defines.svh]
/*
 * Constants of the muting fault monitor: register offsets, field positions,
 * reset values, fault codes and timing figures.
 * Assumes a 100 MHz pclk and a 1 ms supervision tick.
 */
`ifndef MFM_DEFINES_SVH
`define MFM_DEFINES_SVH

`define MFM_ADDR_CTRL 12'h000
`define MFM_ADDR_MASK 12'h004
`define MFM_ADDR_STATUS 12'h008
`define MFM_ADDR_INIT_MS 12'h00C
`define MFM_ADDR_OVR_MS 12'h010

`define MFM_CTRL_SEQ_BIT 0
`define MFM_CTRL_PAIRS_BIT 1
`define MFM_CTRL_PART_BIT 2
`define MFM_CTRL_REV_BIT 3
`define MFM_RST_CTRL 4'h0
`define MFM_RST_INIT_MS 16'h0FA0
`define MFM_RST_OVR_MS 16'h7530

`define MFM_ST_VALID_BIT 8
`define MFM_ST_MUTED_BIT 9
`define MFM_ST_OVR_BIT 10
`define MFM_ST_OUT_BIT 11

`define MFM_CODE_NONE 8'h00
`define MFM_CODE_INIT_TMO 8'h35
`define MFM_CODE_PAIR2_TMO 8'h36
`define MFM_CODE_WITHDRAWN 8'h37
`define MFM_CODE_SEQ_WRONG 8'h38
`define MFM_CODE_SWAP_12 8'h39
`define MFM_CODE_DEACT_1 8'h3C
`define MFM_CODE_DEACT_2 8'h3D
`define MFM_CODE_END_RISE 8'h3E
`define MFM_CODE_PERMIT_TMO 8'h3F
`define MFM_CODE_PERMIT_EARLY 8'h40
`define MFM_CODE_END_FIELD 8'h42
`define MFM_CODE_PRE_FIELD 8'h43
`define MFM_CODE_HALT_FIELD 8'h4B
`define MFM_CODE_HALT_SENSOR 8'h4C
`define MFM_CODE_HALT_TMO 8'h4D
`define MFM_CODE_PARTIAL 8'h50
`define MFM_CODE_SLAVE_OFF 8'h51
`define MFM_CODE_OVR_TMO 8'h5A

`define MFM_CLK_NS 10
`define MFM_TICK_NS 1000000
`define MFM_TICK_CYC (`MFM_TICK_NS / `MFM_CLK_NS)
`define MFM_PERMIT_S 300
`define MFM_PERMIT_MS (`MFM_PERMIT_S * 1000)
`define MFM_HALT_H 8
`define MFM_HALT_MS (`MFM_HALT_H * 3600 * 1000)

`endif

// [shared/mfm_pkg.sv]
/*
 * Types of the muting fault monitor.
 * Assumes mfm_defines.svh for all numeric constants other than the state encodings.
 */
package mfm_pkg;

    typedef enum logic [4:0] {
        MFM_IDLE = 5'h01,
        MFM_ACT = 5'h02,
        MFM_MUTED = 5'h04,
        MFM_ENDING = 5'h08,
        MFM_FAULT = 5'h10
    } mfm_state_t;

    typedef struct packed {
        logic rev;
        logic partial;
        logic pairs;
        logic seq;
    } mfm_ctrl_t;

    typedef struct packed {
        logic out_on;
        logic ovr;
        logic muted;
        logic valid;
        logic [7:0] code;
    } mfm_status_t;

endpackage

// [verilog/mfm_top.sv]
/*
 * Muting supervision and fault code latch with an APB register slave.
 * Assumes all inputs synchronous to pclk and four muting sensor inputs.
 */
`timescale 1ns/1ps
`include "mfm_defines.svh"

module mfm_top #(
    parameter int NB = 16,
    parameter int unsigned TICK_CYC = `MFM_TICK_CYC,
    parameter int unsigned PERMIT_MS = `MFM_PERMIT_MS,
    parameter int unsigned HALT_MS = `MFM_HALT_MS
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [3:0] muting_sensor, // Muting sensor signals
    input wire logic muting_permit, // Muting permit input
    input wire logic belt_stop_req, // Conveyor halt request
    input wire logic override_req, // Static override request
    input wire logic field_clear, // Protective field free
    input wire logic [NB-1:0] beam_blocked, // Per-beam interruption
    input wire logic slave_outputs_on, // Chained slave outputs on
    output logic safety_switch_outputs, // Safety outputs on
    output logic [7:0] fault_code, // Shown fault code
    output logic fault_valid, // Code present
    output logic muting_active, // Muting in force
    output logic override_timeout // Override timed out
);

    // ------------------------------------------------------------
    // Registers and bus
    // ------------------------------------------------------------
    mfm_pkg::mfm_ctrl_t ctrl;
    logic [NB-1:0] mute_mask;
    logic [15:0] init_ms_lim;
    logic [15:0] ovr_ms_lim;
    mfm_pkg::mfm_status_t status;
    mfm_pkg::mfm_state_t state;
    mfm_pkg::mfm_state_t next_state;
    logic [2:0] pos;
    logic [2:0] next_pos;
    logic dir;
    logic next_dir;
    logic [7:0] det;
    logic new_cycle;
    logic [7:0] code;
    logic valid;
    logic [3:0] ms_prev;
    logic field_prev;
    logic permit_prev;
    logic [3:0] rise;
    logic [3:0] fall;
    logic tick;
    logic [31:0] tick_cnt;
    logic [31:0] init_ms;
    logic [31:0] permit_ms;
    logic [31:0] halt_ms;
    logic [31:0] ovr_ms;
    logic ovr_expired;
    logic [2:0] ns;
    logic [2:0] end_cnt;
    logic halt;
    logic acc;

    assign acc = psel & penable & ~pready;
    assign status = '{out_on: safety_switch_outputs, ovr: override_timeout,
                      muted: muting_active, valid: fault_valid, code: fault_code};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (acc) begin
                if (paddr == `MFM_ADDR_CTRL) begin
                    prdata <= {28'h000_0000, ctrl};
                end else if (paddr == `MFM_ADDR_MASK) begin
                    prdata <= 32'(mute_mask);
                end else if (paddr == `MFM_ADDR_STATUS) begin
                    prdata <= {20'h0_0000, status};
                end else if (paddr == `MFM_ADDR_INIT_MS) begin
                    prdata <= {16'h0000, init_ms_lim};
                end else if (paddr == `MFM_ADDR_OVR_MS) begin
                    prdata <= {16'h0000, ovr_ms_lim};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `MFM_RST_CTRL;
            mute_mask <= '0;
            init_ms_lim <= `MFM_RST_INIT_MS;
            ovr_ms_lim <= `MFM_RST_OVR_MS;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == `MFM_ADDR_CTRL) begin
                ctrl <= pwdata[3:0];
            end else if (paddr == `MFM_ADDR_MASK) begin
                mute_mask <= pwdata[NB-1:0];
            end else if (paddr == `MFM_ADDR_INIT_MS) begin
                init_ms_lim <= pwdata[15:0];
            end else if (paddr == `MFM_ADDR_OVR_MS) begin
                ovr_ms_lim <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Millisecond tick and edges
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (tick_cnt >= TICK_CYC - 1) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_prev <= 4'h0;
            field_prev <= 1'b1;
            permit_prev <= 1'b0;
        end else begin
            ms_prev <= muting_sensor;
            field_prev <= field_clear;
            permit_prev <= muting_permit;
        end
    end

    assign rise = muting_sensor & ~ms_prev;
    assign fall = ~muting_sensor & ms_prev;
    assign ns = ctrl.pairs ? 3'h4 : 3'h2;
    assign end_cnt = ctrl.pairs ? 3'h2 : 3'h1;
    assign halt = belt_stop_req & (state == mfm_pkg::MFM_MUTED);

    // Sensor index of sequence position p for a direction
    function automatic logic [1:0] pidx(input logic [2:0] p, input logic r, input logic tp);
        logic [1:0] last;
        last = tp ? 2'h3 : 2'h1;
        pidx = r ? last - p[1:0] : p[1:0];
    endfunction

    // ------------------------------------------------------------
    // Sequence supervision
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_pos = pos;
        next_dir = dir;
        det = `MFM_CODE_NONE;
        new_cycle = 1'b0;
        case (state)
            mfm_pkg::MFM_IDLE: begin
                if (|rise) begin
                    new_cycle = 1'b1;
                    next_pos = 3'h1;
                    next_state = mfm_pkg::MFM_ACT;
                    if (rise[pidx(3'h0, 1'b0, ctrl.pairs)] && !(ctrl.seq && ctrl.rev)) begin
                        next_dir = 1'b0;
                    end else if (rise[pidx(3'h0, 1'b1, ctrl.pairs)] && !(ctrl.seq && !ctrl.rev)) begin
                        next_dir = 1'b1;
                    end else if (rise[pidx(3'h1, ctrl.rev, ctrl.pairs)]) begin
                        det = `MFM_CODE_SWAP_12;
                    end else begin
                        det = `MFM_CODE_SEQ_WRONG;
                    end
                end
            end
            mfm_pkg::MFM_ACT: begin
                if (!slave_outputs_on) begin
                    det = `MFM_CODE_SLAVE_OFF;
                end else if (|(fall & ms_prev)) begin
                    det = `MFM_CODE_WITHDRAWN;
                end else if (pos < ns && rise[pidx(pos, dir, ctrl.pairs)]) begin
                    next_pos = pos + 3'h1;
                end else if (pos + 3'h1 < ns && rise[pidx(pos + 3'h1, dir, ctrl.pairs)]) begin
                    det = `MFM_CODE_SWAP_12 + 8'(pos);
                end else if (ctrl.seq && |rise) begin
                    det = `MFM_CODE_SEQ_WRONG;
                end else if (!muting_permit && permit_prev) begin
                    det = `MFM_CODE_PERMIT_EARLY;
                end else if (!field_clear) begin
                    det = `MFM_CODE_PRE_FIELD;
                end else if (init_ms >= 32'(init_ms_lim)) begin
                    det = (ctrl.pairs && pos >= 3'h2) ? `MFM_CODE_PAIR2_TMO : `MFM_CODE_INIT_TMO;
                end else if (pos == ns && muting_permit) begin
                    next_state = mfm_pkg::MFM_MUTED;
                    next_pos = 3'h0;
                end
            end
            mfm_pkg::MFM_MUTED: begin
                if (!slave_outputs_on) begin
                    det = `MFM_CODE_SLAVE_OFF;
                end else if (halt) begin
                    if (field_clear != field_prev) begin
                        det = `MFM_CODE_HALT_FIELD;
                    end else if (muting_sensor != ms_prev) begin
                        det = `MFM_CODE_HALT_SENSOR;
                    end else if (halt_ms >= HALT_MS) begin
                        det = `MFM_CODE_HALT_TMO;
                    end
                end else if (ctrl.partial && |(beam_blocked & ~mute_mask)) begin
                    det = `MFM_CODE_PARTIAL;
                end else if (|fall) begin
                    if (fall[pidx(pos, dir, ctrl.pairs)]) begin
                        next_pos = pos + 3'h1;
                        if (pos + 3'h1 == end_cnt) begin
                            next_state = mfm_pkg::MFM_ENDING;
                            if (!field_clear) begin
                                det = `MFM_CODE_END_FIELD;
                            end
                        end
                    end else begin
                        det = (pos == 3'h0) ? `MFM_CODE_DEACT_1 : `MFM_CODE_DEACT_2;
                    end
                end
            end
            mfm_pkg::MFM_ENDING: begin
                if (|rise) begin
                    det = `MFM_CODE_END_RISE;
                end else if (muting_sensor == 4'h0) begin
                    next_state = mfm_pkg::MFM_IDLE;
                end
            end
            mfm_pkg::MFM_FAULT: begin
                if (muting_sensor == 4'h0) begin
                    next_state = mfm_pkg::MFM_IDLE;
                end
            end
            default: begin
                next_state = mfm_pkg::MFM_FAULT;
            end
        endcase
        if (det == `MFM_CODE_NONE && permit_ms == PERMIT_MS && tick) begin
            det = `MFM_CODE_PERMIT_TMO;
        end
        if (det != `MFM_CODE_NONE) begin
            next_state = mfm_pkg::MFM_FAULT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= mfm_pkg::MFM_IDLE;
            pos <= 3'h0;
            dir <= 1'b0;
        end else begin
            state <= next_state;
            pos <= next_pos;
            dir <= next_dir;
        end
    end

    // ------------------------------------------------------------
    // Fault code latch
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code <= `MFM_CODE_NONE;
            valid <= 1'b0;
        end else if (new_cycle) begin
            code <= det;
            valid <= det != `MFM_CODE_NONE;
        end else if (det != `MFM_CODE_NONE && !valid) begin
            code <= det;
            valid <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Duration counters
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_ms <= 32'h0000_0000;
        end else if (next_state != mfm_pkg::MFM_ACT || state != mfm_pkg::MFM_ACT
                     || (ctrl.pairs && next_pos == 3'h2 && pos != 3'h2)) begin
            init_ms <= 32'h0000_0000;
        end else if (tick && init_ms != 32'hFFFF_FFFF) begin
            init_ms <= init_ms + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            permit_ms <= 32'h0000_0000;
        end else if (!muting_permit) begin
            permit_ms <= 32'h0000_0000;
        end else if (tick && permit_ms <= PERMIT_MS) begin
            permit_ms <= permit_ms + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_ms <= 32'h0000_0000;
        end else if (!halt) begin
            halt_ms <= 32'h0000_0000;
        end else if (tick && halt_ms < HALT_MS) begin
            halt_ms <= halt_ms + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_ms <= 32'h0000_0000;
            ovr_expired <= 1'b0;
        end else if (!override_req) begin
            ovr_ms <= 32'h0000_0000;
            ovr_expired <= 1'b0;
        end else if (ovr_ms >= 32'(ovr_ms_lim)) begin
            ovr_expired <= 1'b1;
        end else if (tick) begin
            ovr_ms <= ovr_ms + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            safety_switch_outputs <= 1'b0;
            muting_active <= 1'b0;
            fault_code <= `MFM_CODE_NONE;
            fault_valid <= 1'b0;
            override_timeout <= 1'b0;
        end else begin
            muting_active <= next_state == mfm_pkg::MFM_MUTED;
            safety_switch_outputs <= slave_outputs_on
                                     & (field_clear | (next_state == mfm_pkg::MFM_MUTED));
            override_timeout <= ovr_expired;
            fault_code <= ovr_expired ? `MFM_CODE_OVR_TMO : code;
            fault_valid <= ovr_expired | valid;
        end
    end

endmodule

// [test/mfm_checker.sv]
/* Port assertions of the muting fault monitor.
   Bound to mfm_top below; needs mfm_defines.svh on the include path. */
`timescale 1ns/1ps
`include "mfm_defines.svh"

module mfm_checker (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic [3:0] muting_sensor, // Sensor levels
    input wire logic override_req, // Override key
    input wire logic slave_outputs_on, // Slave on
    input wire logic safety_switch_outputs, // Outputs on
    input wire logic [7:0] fault_code, // Shown code
    input wire logic fault_valid, // Code present
    input wire logic muting_active, // Muting on
    input wire logic override_timeout // Override expired
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Sequences and assertions
    // ----------------------------------------
    sequence s_code_held;
        fault_valid && !override_timeout && muting_sensor != 4'h0 && $past(muting_sensor) != 4'h0
            && $past(muting_sensor, 2) != 4'h0;
    endsequence
    sequence s_slave_drop;
        $fell(slave_outputs_on) && muting_active && !fault_valid && !override_req;
    endsequence

    wait_state_a:
        assert property (psel && penable && !pready |=> pready) else $error("no ready after wait state");
    ready_pulse_a:
        assert property (pready |=> !pready) else $error("ready longer than one cycle");
    err_rdata_a:
        assert property (pslverr |-> pready && prdata == 32'h0) else $error("error without ready or zero data");
    code_valid_a:
        assert property (!override_timeout |-> fault_valid == (fault_code != 8'h00)) else $error("valid mismatch");
    first_kept_a:
        assert property (s_code_held |=> override_timeout || (fault_valid && fault_code == $past(fault_code)))
            else $error("latched code replaced");
    ovr_code_a:
        assert property (override_timeout |-> fault_code == `MFM_CODE_OVR_TMO) else $error("override code missing");
    ovr_key_a:
        assert property (override_timeout |-> $past(override_req, 2)) else $error("override shown without key");
    slave_off_a:
        assert property (!slave_outputs_on |=> !safety_switch_outputs) else $error("outputs on with slave off");
    slave_code_a:
        assert property (s_slave_drop |-> ##2 (override_timeout || fault_code == `MFM_CODE_SLAVE_OFF))
            else $error("slave off code missing");
    fault_unmuted_a:
        assert property (fault_valid && $past(fault_valid) && !override_timeout |-> !muting_active)
            else $error("muting kept on fault");
endmodule

bind mfm_top mfm_checker chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .muting_sensor(muting_sensor), .override_req(override_req),
    .slave_outputs_on(slave_outputs_on), .safety_switch_outputs(safety_switch_outputs),
    .fault_code(fault_code), .fault_valid(fault_valid), .muting_active(muting_active),
    .override_timeout(override_timeout)
);

// [test/mfm_plant.sv]
/* Model of the muting sensors and machine control around the monitor.
   Runs on pclk; the bench calls its tasks and may drive its outputs. */
`timescale 1ns/1ps

module mfm_plant (
    input wire logic pclk, // Clock
    output logic [3:0] muting_sensor, // Sensor levels
    output logic muting_permit, // Permit
    output logic belt_stop_req, // Conveyor halt
    output logic override_req, // Override key
    output logic field_clear, // Field free
    output logic [15:0] beam_blocked, // Beams hit
    output logic slave_outputs_on // Slave on
);
    initial begin
        muting_sensor = 4'h0;
        muting_permit = 1'b0;
        belt_stop_req = 1'b0; // Halt only raised by t_halt, held until the following new_cycle lowers it
        override_req = 1'b0;
        field_clear = 1'b1;
        beam_blocked = 16'h0000;
        slave_outputs_on = 1'b1;
    end

    // Sensors 0 then 1 in order, permit held until both active
    task automatic enter(input int gap);
        @(posedge pclk);
        muting_permit <= 1'b1;
        muting_sensor <= 4'h1;
        repeat (gap) @(posedge pclk);
        muting_sensor <= 4'h3;
        repeat (4) @(posedge pclk);
        muting_permit <= 1'b0; // Far below the permit limit
    endtask

    // Machine inputs: halt, override, field free, slave on, beams
    task automatic ctl(input logic [19:0] v);
        {belt_stop_req, override_req, field_clear, slave_outputs_on, beam_blocked} <= v;
    endtask

    task automatic leave(input int gap);
        @(posedge pclk);
        muting_sensor <= 4'h2;
        repeat (gap) @(posedge pclk);
        muting_sensor <= 4'h0;
        repeat (4) @(posedge pclk);
    endtask
endmodule

// [test/mfm_tb_top.sv]
/* Self-checking bench of the muting fault monitor.
   Holds mfm_top, the plant model and the bound checker. */
`timescale 1ns/1ps
`include "mfm_defines.svh"

module mfm_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, permit, belt, ovr, fclr, slave_on, outs, fvalid, mact, otmo;
    logic [3:0] sens;
    logic [15:0] beams;
    logic [7:0] code;
    int error_cnt = 0;
    int total_checks = 0;

    always #5 pclk = ~pclk;

    mfm_top #(.TICK_CYC(10), .PERMIT_MS(20), .HALT_MS(30)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .muting_sensor(sens), .muting_permit(permit), .belt_stop_req(belt), .override_req(ovr),
        .field_clear(fclr), .beam_blocked(beams), .slave_outputs_on(slave_on),
        .safety_switch_outputs(outs), .fault_code(code), .fault_valid(fvalid),
        .muting_active(mact), .override_timeout(otmo)
    );
    mfm_plant plant (
        .pclk(pclk), .muting_sensor(sens), .muting_permit(permit), .belt_stop_req(belt),
        .override_req(ovr), .field_clear(fclr), .beam_blocked(beams), .slave_outputs_on(slave_on)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic expect_code(input logic [7:0] exp);
        cyc(3);
        chk({24'h0, code}, {24'h0, exp}, "code");
        chk({31'h0, fvalid}, {31'h0, exp != 8'h00}, "valid");
    endtask
    // Clean muting cycle, clears any shown code
    task automatic new_cycle();
        plant.muting_sensor <= 4'h0;
        plant.muting_permit <= 1'b0;
        plant.ctl(20'h3_0000);
        cyc(3);
        plant.enter(2);
        chk({31'h0, mact}, 32'h1, "muted");
        plant.leave(2);
        expect_code(8'h00);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(1'b0, `MFM_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0, "ctrl");
        apb(1'b0, `MFM_ADDR_INIT_MS, 32'h0);
        chk(rd, 32'h0000_0FA0, "init");
        apb(1'b0, `MFM_ADDR_OVR_MS, 32'h0);
        chk(rd, 32'h0000_7530, "ovr");
        apb(1'b0, `MFM_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_0800, "status");
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h1, "slverr");
        apb(1'b1, `MFM_ADDR_INIT_MS, 32'h5);
        apb(1'b0, `MFM_ADDR_INIT_MS, 32'h0);
        chk({31'h0, er}, 32'h0, "no err");
        chk(rd, 32'h5, "init wr");
    endtask
    task automatic t_first();
        plant.muting_sensor <= 4'h1;
        cyc(2);
        plant.ctl(20'h1_0000);
        expect_code(`MFM_CODE_PRE_FIELD);
        plant.muting_sensor <= 4'h2;
        expect_code(`MFM_CODE_PRE_FIELD);
    endtask
    task automatic t_withdrawn();
        plant.muting_sensor <= 4'h1;
        cyc(2);
        plant.muting_sensor <= 4'h0;
        expect_code(`MFM_CODE_WITHDRAWN);
    endtask
    task automatic t_init_tmo();
        plant.muting_sensor <= 4'h1;
        cyc(80);
        expect_code(`MFM_CODE_INIT_TMO);
    endtask
    task automatic t_permit_early();
        plant.muting_permit <= 1'b1;
        plant.muting_sensor <= 4'h1;
        cyc(2);
        plant.muting_permit <= 1'b0;
        expect_code(`MFM_CODE_PERMIT_EARLY);
    endtask
    task automatic t_seq();
        apb(1'b1, `MFM_ADDR_CTRL, 32'h3);
        plant.muting_sensor <= 4'h4;
        expect_code(`MFM_CODE_SEQ_WRONG);
        apb(1'b1, `MFM_ADDR_CTRL, 32'h0);
    endtask
    task automatic t_end_rise();
        plant.enter(2);
        plant.muting_sensor <= 4'h2;
        cyc(2);
        plant.muting_sensor <= 4'h3;
        expect_code(`MFM_CODE_END_RISE);
    endtask
    task automatic t_deact();
        plant.enter(2);
        plant.muting_sensor <= 4'h1;
        expect_code(`MFM_CODE_DEACT_1);
    endtask
    task automatic t_end_field();
        plant.enter(2);
        plant.ctl(20'h1_0000);
        cyc(2);
        plant.muting_sensor <= 4'h2;
        expect_code(`MFM_CODE_END_FIELD);
    endtask
    task automatic t_slave();
        plant.enter(2);
        plant.ctl(20'h2_0000);
        expect_code(`MFM_CODE_SLAVE_OFF);
        chk({31'h0, outs}, 32'h0, "outputs");
        chk({31'h0, mact}, 32'h0, "muting");
    endtask
    task automatic t_halt(input int k);
        plant.enter(2);
        plant.ctl(20'hB_0000);
        cyc(2);
        if (k == 0) plant.ctl(20'h9_0000);
        if (k == 1) plant.muting_sensor <= 4'h2;
        if (k == 2) cyc(330);
        expect_code(k == 0 ? `MFM_CODE_HALT_FIELD : k == 1 ? `MFM_CODE_HALT_SENSOR : `MFM_CODE_HALT_TMO);
    endtask
    task automatic t_partial();
        apb(1'b1, `MFM_ADDR_MASK, 32'h3);
        apb(1'b1, `MFM_ADDR_CTRL, 32'h4);
        plant.enter(2);
        plant.ctl(20'h3_0001);
        expect_code(8'h00);
        plant.ctl(20'h3_0100);
        expect_code(`MFM_CODE_PARTIAL);
        apb(1'b1, `MFM_ADDR_CTRL, 32'h0);
    endtask
    task automatic t_override();
        apb(1'b1, `MFM_ADDR_OVR_MS, 32'h3);
        plant.ctl(20'h7_0000);
        cyc(60);
        chk({31'h0, otmo}, 32'h1, "ovr tmo");
        chk({24'h0, code}, {24'h0, `MFM_CODE_OVR_TMO}, "ovr code");
        plant.ctl(20'h3_0000);
        cyc(3);
        chk({31'h0, otmo}, 32'h0, "ovr off");
        chk({24'h0, code}, 32'h0, "ovr code off");
    endtask
    task automatic t_permit_tmo();
        plant.muting_permit <= 1'b1;
        cyc(230);
        expect_code(`MFM_CODE_PERMIT_TMO);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #300000;
        error_cnt++;
        final_report();
    end

    initial begin
        cyc(6);
        presetn <= 1'b1;
        t_regs();
        new_cycle();
        t_first();
        new_cycle();
        t_withdrawn();
        new_cycle();
        t_init_tmo();
        new_cycle();
        t_permit_early();
        new_cycle();
        t_seq();
        new_cycle();
        t_end_rise();
        new_cycle();
        t_deact();
        new_cycle();
        t_end_field();
        new_cycle();
        t_slave();
        new_cycle();
        for (int k = 0; k < 3; k++) begin
            t_halt(k);
            new_cycle();
        end
        t_partial();
        new_cycle();
        t_override();
        t_permit_tmo();
        new_cycle();
        final_report();
    end
endmodule
